/* hdl/ecf_pkg.sv */
// Purpose: shared constants and types for the external code fetch bus
// Assumes: one clock, REF_CLK_I is the oscillator clock
// Notes:   phase counts are in cpu clocks of one bus cycle
`default_nettype none
package ecf_pkg;
  // bus cycle length in cpu clocks
  localparam int unsigned CPU_CLKS_PER_CYCLE = 6;
  // oscillator periods per cpu clock in each mode
  localparam int unsigned OSC_PER_CPU_STD    = 2;
  localparam int unsigned OSC_PER_CPU_DBL    = 1;
  // cpu clock phases of one bus cycle
  localparam logic [2:0]  PH_ALE_END         = 3'h2; // strobe high in phases 0..1
  localparam logic [2:0]  PH_STROBE_START    = 3'h3; // store strobe low 3..5
  localparam logic [2:0]  PH_LAST            = 3'h5;
  // code space layout
  localparam int unsigned CODE_ADDR_W        = 16;
  localparam logic [15:0] ONCHIP_16K_TOP     = 16'h3fff;
  localparam logic [15:0] ONCHIP_32K_TOP     = 16'h7fff;

  // fetch request from the core
  typedef struct packed {
    logic [15:0] addr;     // code byte address
    logic        constant; // code constant read, not a fetch
  } ecf_req_s;

  // pin group facing the external memory
  typedef struct packed {
    logic [7:0] low_port_o;   // muxed address and data out
    logic [7:0] low_port_oe;  // low port output enable
    logic [7:0] high_port_o;  // upper address lines
    logic       ale_o;        // address latch strobe
    logic       program_store_strobe_n; // active low
  } ecf_pins_s;
endpackage : ecf_pkg
`default_nettype wire

/* hdl/ecf_phase_timer.sv */
// Purpose: divides the oscillator into cpu clock ticks for one bus cycle
// Assumes: mode held stable while a cycle is running
// Notes:   tick marks the last oscillator period of each cpu clock
`default_nettype none
module ecf_phase_timer #(
  parameter int unsigned CNT_W = 2
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic run_i,       // bus cycle active
  input  wire logic dbl_i,       // double-speed mode
  output logic      tick_o       // end of one cpu clock
);
  import ecf_pkg::*;
  logic [CNT_W-1:0] cnt_reg;   // oscillator count in a cpu clock
  logic [CNT_W-1:0] cnt_next;
  logic [CNT_W-1:0] limit;     // last count of a cpu clock

  // limit per mode: two periods standard, one double-speed
  always_comb begin
    limit  = dbl_i ? CNT_W'(OSC_PER_CPU_DBL - 1) : CNT_W'(OSC_PER_CPU_STD - 1);
    tick_o = run_i && (cnt_reg == limit);
    if (!run_i || tick_o) begin
      cnt_next = '0;
    end else begin
      cnt_next = cnt_reg + CNT_W'(1);
    end
  end

  // register only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule : ecf_phase_timer
`default_nettype wire

/* hdl/ecf_fetch_bus.sv */
// Purpose: external code fetch bus of a small 8-bit controller
// Assumes: low port data input is asynchronous and synchronised here
// Notes:   one request per bus cycle; on-chip hits never touch the pins, except a fetch of the top on-chip byte
// Operation
// - low port low address, high port high
// - low port carries address then data
// - latch strobe marks valid low address
// - store strobe low only on external reads
// - each bus cycle is six cpu clocks
// - twelve or six oscillator periods per cycle
// - top on-chip fetch prefetches externally
// - top on-chip constant read stays internal
// - 16 or 32 Kbyte on-chip code
// - reset starts in standard clock mode
`default_nettype none
module ecf_fetch_bus #(
  parameter bit ONCHIP_32K = 1'b0 // variant: 32 Kbyte on-chip code
) (
  input  wire logic              REF_CLK_I,
  input  wire logic              RST_I,
  input  wire logic              DOUBLE_SPEED_MODE_I, // double-speed clock select
  input  wire logic              REQ_VALID_I,         // core request
  input  wire ecf_pkg::ecf_req_s REQ_I,
  output logic                   REQ_READY_O,         // request taken
  output logic                   RSP_VALID_O,         // one-cycle answer pulse
  output logic [7:0]             RSP_DATA_O,          // external byte read
  output logic                   RSP_EXTERNAL_O,      // answer came from pins
  input  wire logic [7:0]        LOW_PORT_I,          // muxed lines in
  output ecf_pkg::ecf_pins_s     PINS_O
);
  import ecf_pkg::*;

  typedef enum logic [0:0] {ECF_IDLE, ECF_BUS} ecf_state_e;

  ecf_state_e  state_reg, state_next;        // bus cycle state
  logic [2:0]  phase_reg, phase_next;        // cpu clock phase
  logic [15:0] addr_reg, addr_next;          // latched address
  logic        dbl_reg, dbl_next;            // mode latched per cycle
  logic [7:0]  data_reg, data_next;          // sampled byte
  logic        rsp_reg, rsp_next;            // answer pulse
  logic        ext_reg, ext_next;            // answer external flag
  logic [7:0]  sync1_reg, sync2_reg;         // low port synchroniser
  logic [15:0] top_addr;                     // highest on-chip byte
  logic        ext_hit;                      // request needs the pins
  logic        tick;                         // cpu clock boundary
  logic [3:0]  bus_len_reg, bus_len_next;    // check helper: periods in a cycle

  // on-chip size per variant
  assign top_addr = ONCHIP_32K ? ONCHIP_32K_TOP : ONCHIP_16K_TOP;
  // top byte fetch prefetches outside, constant read does not
  always_comb begin
    ext_hit = (REQ_I.addr > top_addr) ||
              ((REQ_I.addr == top_addr) && !REQ_I.constant);
  end

  // cpu clock divider
  ecf_phase_timer #(.CNT_W(2)) u_timer (
    .clk_i  (REF_CLK_I),
    .rst_i  (RST_I),
    .run_i  (state_reg == ECF_BUS),
    .dbl_i  (dbl_reg),
    .tick_o (tick)
  );

  // two-flop synchroniser on the external data lines
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
    end else begin
      sync1_reg <= LOW_PORT_I;
      sync2_reg <= sync1_reg;
    end
  end

  assign REQ_READY_O = (state_reg == ECF_IDLE);

  // bus cycle sequencing
  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    addr_next  = addr_reg;
    dbl_next   = dbl_reg;
    data_next  = data_reg;
    rsp_next   = 1'b0;
    ext_next   = ext_reg;
    case (state_reg)
      ECF_IDLE: begin
        dbl_next = DOUBLE_SPEED_MODE_I;
        if (REQ_VALID_I) begin
          if (ext_hit) begin
            state_next = ECF_BUS;
            phase_next = 3'h0;
            addr_next  = REQ_I.addr;
          end else begin
            rsp_next   = 1'b1; // internal hit, pins untouched
            ext_next   = 1'b0;
          end
        end
      end
      ECF_BUS: begin
        if (tick) begin
          if (phase_reg == PH_LAST) begin // six cpu clocks done
            state_next = ECF_IDLE;
            data_next  = sync2_reg;       // sample before strobe rises
            rsp_next   = 1'b1;
            ext_next   = 1'b1;
          end else begin
            phase_next = phase_reg + 3'h1;
          end
        end
      end
      default: begin
        state_next = ECF_IDLE;
      end
    endcase
  end

  // state registers; reset in standard clock mode
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      state_reg <= ECF_IDLE;
      phase_reg <= 3'h0;
      addr_reg  <= 16'h0000;
      dbl_reg   <= 1'b0;
      data_reg  <= 8'h00;
      rsp_reg   <= 1'b0;
      ext_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      addr_reg  <= addr_next;
      dbl_reg   <= dbl_next;
      data_reg  <= data_next;
      rsp_reg   <= rsp_next;
      ext_reg   <= ext_next;
    end
  end

  assign RSP_VALID_O    = rsp_reg;
  assign RSP_DATA_O     = data_reg;
  assign RSP_EXTERNAL_O = ext_reg;

  // pin outputs from registered state
  always_comb begin
    logic busy;
    busy = (state_reg == ECF_BUS);
    PINS_O.high_port_o = addr_reg[15:8];
    PINS_O.low_port_o  = addr_reg[7:0];
    // address while strobe high, released for data afterwards
    PINS_O.low_port_oe = (busy && phase_reg < PH_ALE_END) ? 8'hff : 8'h00;
    PINS_O.ale_o       = busy && (phase_reg < PH_ALE_END);
    PINS_O.program_store_strobe_n = !(busy && phase_reg >= PH_STROBE_START);
  end

  // check helper: counts oscillator periods spent in the running bus cycle,
  // so the standard length is judged on a counter, not a long repetition
  always_comb begin
    if (state_reg == ECF_BUS) begin
      bus_len_next = bus_len_reg + 4'h1; // one more period in the cycle
    end else begin
      bus_len_next = 4'h0;               // cleared between cycles
    end
  end

  // check helper register only
  always_ff @(posedge REF_CLK_I) begin
    if (RST_I) begin
      bus_len_reg <= 4'h0;
    end else begin
      bus_len_reg <= bus_len_next;
    end
  end

  // checks
  // a reset that cuts a cycle short is kept out of the length checks
  chk_strobe_idle: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    state_reg == ECF_IDLE |-> PINS_O.program_store_strobe_n)
    else $error("store strobe low outside bus cycle");
  chk_ale_address: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    PINS_O.ale_o |-> PINS_O.low_port_oe == 8'hff && PINS_O.low_port_o == addr_reg[7:0])
    else $error("latch strobe without address on low port");
  chk_addr_pins: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    state_reg == ECF_BUS |-> PINS_O.high_port_o == addr_reg[15:8] &&
    PINS_O.low_port_o == addr_reg[7:0])
    else $error("address pins differ from cycle address");
  chk_no_overlap: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !PINS_O.program_store_strobe_n |-> PINS_O.low_port_oe == 8'h00 && !PINS_O.ale_o)
    else $error("low port driven during data phase");
  chk_std_length: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    $fell(state_reg == ECF_BUS) && !dbl_reg && !$past(RST_I) |->
    bus_len_reg == 4'(CPU_CLKS_PER_CYCLE * OSC_PER_CPU_STD))
    else $error("standard cycle not twelve oscillator periods");
  chk_dbl_length: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    $rose(state_reg == ECF_BUS) && dbl_reg |-> (state_reg == ECF_BUS) [*6] ##1
    state_reg == ECF_IDLE)
    else $error("double-speed cycle not six oscillator periods");
  chk_const_top: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    REQ_VALID_I && REQ_READY_O && REQ_I.constant && REQ_I.addr == top_addr
    |=> state_reg == ECF_IDLE && RSP_VALID_O && !RSP_EXTERNAL_O)
    else $error("top constant read went external");
  chk_fetch_top: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    REQ_VALID_I && REQ_READY_O && !REQ_I.constant && REQ_I.addr == top_addr
    |=> state_reg == ECF_BUS)
    else $error("top fetch did not prefetch externally");
  chk_sample: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    RSP_VALID_O && RSP_EXTERNAL_O |-> RSP_DATA_O == $past(sync2_reg) &&
    !$past(PINS_O.program_store_strobe_n))
    else $error("byte not sampled under store strobe");
  chk_reset_mode: assert property (@(posedge REF_CLK_I)
    $past(RST_I) |-> !dbl_reg)
    else $error("not standard mode after reset");

  cov_ext_std: cover property (@(posedge REF_CLK_I) disable iff (RST_I)
    RSP_VALID_O && RSP_EXTERNAL_O && !dbl_reg);
  cov_ext_dbl: cover property (@(posedge REF_CLK_I) disable iff (RST_I)
    RSP_VALID_O && RSP_EXTERNAL_O && dbl_reg);
  cov_internal: cover property (@(posedge REF_CLK_I) disable iff (RST_I)
    RSP_VALID_O && !RSP_EXTERNAL_O);
  // both kinds of access to the highest on-chip byte
  cov_top_fetch: cover property (@(posedge REF_CLK_I) disable iff (RST_I)
    REQ_VALID_I && REQ_READY_O && !REQ_I.constant && REQ_I.addr == top_addr);
  cov_top_const: cover property (@(posedge REF_CLK_I) disable iff (RST_I)
    REQ_VALID_I && REQ_READY_O && REQ_I.constant && REQ_I.addr == top_addr);
endmodule : ecf_fetch_bus
`default_nettype wire

/* tb/ecf_mem_model.sv */
// Purpose: external program memory with its address latch
// Assumes: byte at an address is low ^ high ^ 5a
// Notes:   released lines toggle so stale data never reads as valid
`default_nettype none
module ecf_mem_model (
  input  wire logic              clk_i,  // oscillator clock
  input  wire ecf_pkg::ecf_pins_s pins_i, // device pin group
  output logic [7:0]             bus_o   // resolved low port level
);
  timeunit 1ns;
  timeprecision 1ps;
  import ecf_pkg::*;
  logic [7:0] lat_reg  = 8'h00; // latched low address
  logic [7:0] last_reg = 8'h00; // last wire level
  logic [7:0] mem_byte;         // addressed code byte
  // latch open while the strobe is high, holding its last address once the
  // strobe falls; clocked so the pin update and the capture cannot race
  always @(posedge clk_i) begin
    if (pins_i.ale_o) lat_reg <= bus_o;
  end
  // track the wire so a released port keeps changing
  always @(posedge clk_i) last_reg <= bus_o;
  // memory drives only while the store strobe is low
  always_comb begin
    mem_byte = lat_reg ^ pins_i.high_port_o ^ 8'h5a;
    bus_o = (pins_i.low_port_oe & pins_i.low_port_o) | (~pins_i.low_port_oe &
            (pins_i.program_store_strobe_n ? ~last_reg : mem_byte));
  end
endmodule : ecf_mem_model
`default_nettype wire

/* tb/tb_top.sv */
// Purpose: self-checking bench for the external code fetch bus
// Assumes: 16 Kbyte on-chip variant, 100 MHz oscillator
// Notes:   inputs change on the falling edge only
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ecf_pkg::*;
  logic       clk;  // oscillator clock
  logic       rst;  // sync reset
  logic       dbl;  // double-speed select
  logic       vld;  // request valid
  ecf_req_s   req;  // request payload
  logic       rdy;  // request taken
  logic       rv;   // answer pulse
  logic [7:0] rd;   // answer byte
  logic       rext; // answer came from pins
  logic [7:0] bus;  // low port wire
  ecf_pins_s  pins; // pin group
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  // free-running clock
  always #5 clk = ~clk;
  ecf_fetch_bus dut (.REF_CLK_I(clk), .RST_I(rst), .DOUBLE_SPEED_MODE_I(dbl),
    .REQ_VALID_I(vld), .REQ_I(req), .REQ_READY_O(rdy), .RSP_VALID_O(rv),
    .RSP_DATA_O(rd), .RSP_EXTERNAL_O(rext), .LOW_PORT_I(bus), .PINS_O(pins));
  ecf_mem_model u_mem (.clk_i(clk), .pins_i(pins), .bus_o(bus));
  // count a compare, report a mismatch at once
  task automatic check(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      n_fail++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : check
  // one request, timed and judged against the bus cycle shape
  task automatic run(input logic [15:0] a, input logic k, input logic d, input int lat);
    int n;
    int na;
    int ns;
    na = 0;
    ns = 0;
    dbl = d;
    @(negedge clk);
    vld = 1'b1;
    req = '{addr: a, constant: k};
    check(rdy === 1'b1, "not ready");
    @(negedge clk);
    vld = 1'b0;
    n = 1;
    while (rv !== 1'b1 && n < 40) begin
      if (pins.ale_o === 1'b1) begin
        na++;
        check(bus === a[7:0] && pins.high_port_o === a[15:8], "address");
      end
      if (pins.program_store_strobe_n === 1'b0) begin
        ns++;
        check(pins.low_port_oe === 8'h00, "low port driven in data phase");
      end
      @(negedge clk);
      n++;
    end
    check(n == lat, "latency");
    check(na == (lat == 1 ? 0 : lat == 7 ? 2 : 4), "latch strobe width");
    check(ns == (lat == 1 ? 0 : lat == 7 ? 3 : 6), "store strobe width");
    check(rext === (lat != 1), "answer source");
    if (lat != 1) check(rd === (a[7:0] ^ a[15:8] ^ 8'h5a), "data");
    $display("test %h done", a);
  endtask : run
  // reset in the middle of a data phase
  task automatic t_reset_mid();
    dbl = 1'b0;
    vld = 1'b1;
    req = '{addr: 16'h8001, constant: 1'b0};
    @(negedge clk);
    vld = 1'b0;
    repeat (8) @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    check(pins.program_store_strobe_n === 1'b1 && pins.ale_o === 1'b0 &&
          pins.low_port_oe === 8'h00 && rdy === 1'b1 && rv === 1'b0, "reset");
    $display("test mid reset done");
  endtask : t_reset_mid
  // verdict and end of run
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_fail++;
      summarize();
    end
  end
  // main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    dbl = 1'b0;
    vld = 1'b0;
    req = '0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    run(16'h4a5c, 1'b0, 1'b0, 13);
    run(16'hc3a7, 1'b1, 1'b1, 7);
    run(16'h1234, 1'b0, 1'b0, 1);
    run(16'h3fff, 1'b1, 1'b0, 1);
    run(16'h3fff, 1'b0, 1'b1, 7);
    run(16'h4000, 1'b1, 1'b0, 13);
    t_reset_mid();
    run(16'h8001, 1'b0, 1'b0, 13);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
